// File: src/cssup_defs.svh
// Constants of the clock select and supervisor register bank.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CSSUP_DEFS_SVH
`define CSSUP_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSSUP_OFS_CLOCK     8'h1D
`define CSSUP_OFS_STATUS    8'h1E
`define CSSUP_OFS_IRQ_EN    8'h20

// ----------------------------------------------------------------------
// Clock source config fields
// ----------------------------------------------------------------------
`define CSSUP_B_WARN_EN     7
`define CSSUP_B_OVERRIDE    6
`define CSSUP_B_MISSING     5
`define CSSUP_B_CLOCK_OUT_PIN_EN     4
`define CSSUP_B_DIV_HI      3
`define CSSUP_B_DIV_LO      2
`define CSSUP_B_EXT_EN      1
`define CSSUP_B_XTAL_EN     0
`define CSSUP_CLOCK_RST     8'h00

// ----------------------------------------------------------------------
// Status fields and flag indices
// ----------------------------------------------------------------------
`define CSSUP_F_SHDN        3
`define CSSUP_F_TWARN       2
`define CSSUP_F_UV          1
`define CSSUP_F_SWARN       0
`define CSSUP_FLAGS_RST     4'h0
`define CSSUP_IRQ_EN_RST    4'hF
`define CSSUP_WARN_ALWAYS   3'h7

// ----------------------------------------------------------------------
// Crystal divider codes and framer divide ratios
// ----------------------------------------------------------------------
`define CSSUP_DIV_14M       2'h0
`define CSSUP_DIV_7M        2'h1
`define CSSUP_RATIO_14M     3'h4
`define CSSUP_RATIO_7M      3'h2
`define CSSUP_RATIO_3M      3'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CSSUP_SYS_CLK_MHZ   100
`define CSSUP_SYS_CLK_KHZ   100000
`define CSSUP_MISS_TIME_NS  2000
`define CSSUP_MISS_CYC      ((`CSSUP_MISS_TIME_NS * `CSSUP_SYS_CLK_MHZ) / 1000)
`define CSSUP_CLOCK_OUT_PIN_KHZ      3686
`define CSSUP_ACC_W         16

`endif

// File: src/cssup_pkg.sv
// Types of the clock select and supervisor register bank.
// Assumes nothing of its surroundings.
`default_nettype none

package cssup_pkg;

  // ----------------------------------------------------------------------
  // Framer clock source
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CSSUP_SRC_INTERNAL,
    CSSUP_SRC_CRYSTAL,
    CSSUP_SRC_EXT
  } cssup_src_e;

  typedef logic [3:0] cssup_flags_t;
  typedef logic [7:0] cssup_byte_t;

endpackage

`default_nettype wire

// File: src/cssup_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs come from pins or foreign clock domains.
`default_nettype none

module cssup_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("cssup_sync: width must be at least one");
  end

  // The first stage is read by the second stage only.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: src/cssup_top.sv
// Clock source selection and supply/thermal supervision register bank.
// Assumes a single-cycle register port on sys_clk and analog detectors
// and clock pins that are asynchronous to sys_clk.
//
// Added by the designer: strobed register access.
`include "cssup_defs.svh"
`default_nettype none

//Behaviour
//RULE1: Supply warning enable gates its interrupt; live flag always updates.
//RULE2: Override set: line outputs follow register bits, pins ignored.
//RULE3: Register transmit bits act like pins only while override is set.
//RULE4: Failed crystal or input clock: switch to internal, set missing flag.
//RULE5: Software waits 100ms after startup before trusting missing flag.
//RULE6: Clock output enable drives a 3.686MHz clock on the output pin.
//RULE7: Divider code 00 14.745MHz, 01 7.373MHz, 1x 3.686MHz crystal.
//RULE8: Software keeps crystal enable 0 while clock input enable is 1.
//RULE9: Crystal enable starts oscillator; software keeps input enable 0.
//RULE10: No framer and no clock fitted: both enables left at 0.
//RULE11: Latched bits set only on a rising edge of their live flag.
//RULE12: Status read clears latched bits; live bits keep following.
//RULE13: Latched bits raise interrupt; supply warning only when enabled.
//RULE14: Shutdown flag is 1 while in thermal shutdown, else 0.
//RULE15: Thermal warning sets above 135C, clears only below 120C.
//RULE16: Undervoltage flag follows the 9V supply detector.
//RULE17: Supply warning sets below 18V, clears above 15.5V.
//RULE18: Clock register writable bits reset to zero.
module cssup_top #(
  parameter int CHANNELS = 2,
  parameter int MISS_CYC = `CSSUP_MISS_CYC
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [7:0]          reg_rdata,
  // Detectors, asynchronous
  input  wire logic                temp_shutdown_det,
  input  wire logic                temp_above_warn_det,
  input  wire logic                temp_below_clear_det,
  input  wire logic                supply_below_uv_det,
  input  wire logic                supply_below_warn_det,
  input  wire logic                supply_above_recov_det,
  // Clock pins, asynchronous
  input  wire logic                clock_in_pin,
  input  wire logic                crystal_osc_pin,
  output var  logic                crystal_osc_run,
  output var  logic                clock_out_pin,
  output var  logic [1:0]          framer_clk_src,
  output var  logic [2:0]          framer_clk_ratio,
  // Line drive, pins asynchronous, bits from neighbour registers
  input  wire logic [CHANNELS-1:0] tx_pin,
  input  wire logic [CHANNELS-1:0] line_drive_en_pin,
  input  wire logic [CHANNELS-1:0] tx_bit,
  input  wire logic [CHANNELS-1:0] line_drive_en_bit,
  output var  logic [CHANNELS-1:0] line_port_tx,
  output var  logic [CHANNELS-1:0] line_port_drive_en,
  // Interrupt
  output var  logic                global_status_irq
);

  localparam int SYNC_W = 8 + 2 * CHANNELS;
  localparam int CNT_W  = $clog2(MISS_CYC + 1);
  localparam logic [`CSSUP_ACC_W-1:0] CLOCK_OUT_PIN_INC = `CSSUP_ACC_W'(
    (`CSSUP_CLOCK_OUT_PIN_KHZ * (64'd1 << `CSSUP_ACC_W)) / `CSSUP_SYS_CLK_KHZ);

  if (CHANNELS < 1 || MISS_CYC < 2) begin : g_chk
    $error("cssup_top: channel count or clock timeout out of range");
  end

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0]   sync_s;
  logic                shdn_s;
  logic                above_warn_s;
  logic                below_clr_s;
  logic                uv_s;
  logic                sw_below_s;
  logic                sw_above_s;
  logic                clkin_s;
  logic                xtal_s;
  logic [CHANNELS-1:0] tx_pin_s;
  logic [CHANNELS-1:0] en_pin_s;

  cssup_sync #(
    .W (SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({line_drive_en_pin, tx_pin, crystal_osc_pin, clock_in_pin,
                supply_above_recov_det, supply_below_warn_det,
                supply_below_uv_det, temp_below_clear_det,
                temp_above_warn_det, temp_shutdown_det}),
    .sync_out (sync_s)
  );

  assign shdn_s       = sync_s[0];
  assign above_warn_s = sync_s[1];
  assign below_clr_s  = sync_s[2];
  assign uv_s         = sync_s[3];
  assign sw_below_s   = sync_s[4];
  assign sw_above_s   = sync_s[5];
  assign clkin_s      = sync_s[6];
  assign xtal_s       = sync_s[7];
  assign tx_pin_s     = sync_s[8 +: CHANNELS];
  assign en_pin_s     = sync_s[8 + CHANNELS +: CHANNELS];

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic                  wr_clock;
  logic                  wr_status;
  logic                  wr_irq_en;
  logic                  rd_status;
  logic [7:0]            clock_q;
  cssup_pkg::cssup_flags_t irq_en_q;
  cssup_pkg::cssup_flags_t live_q;
  cssup_pkg::cssup_flags_t live_prev_q;
  cssup_pkg::cssup_flags_t latched_q;
  cssup_pkg::cssup_flags_t rise;
  logic                  missing_q;

  assign wr_clock  = reg_wr && (reg_addr == `CSSUP_OFS_CLOCK);
  assign wr_status = reg_wr && (reg_addr == `CSSUP_OFS_STATUS);
  assign wr_irq_en = reg_wr && (reg_addr == `CSSUP_OFS_IRQ_EN);
  assign rd_status = reg_rd && (reg_addr == `CSSUP_OFS_STATUS);

  // The missing flag bit is read-only and never stored from a write.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clock_q <= `CSSUP_CLOCK_RST; // RULE18
    end else if (wr_clock) begin
      clock_q <= reg_wdata;
      clock_q[`CSSUP_B_MISSING] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_en_q <= `CSSUP_IRQ_EN_RST;
    end else if (wr_irq_en) begin
      irq_en_q <= reg_wdata[3:0];
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `CSSUP_OFS_CLOCK: begin
          reg_rdata <= clock_q;
          reg_rdata[`CSSUP_B_MISSING] <= missing_q;
        end
        `CSSUP_OFS_STATUS: reg_rdata <= {latched_q, live_q};
        `CSSUP_OFS_IRQ_EN: reg_rdata <= {4'h0, irq_en_q};
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Live supervision flags
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_q <= `CSSUP_FLAGS_RST;
    end else begin
      live_q[`CSSUP_F_SHDN] <= shdn_s; // RULE14
      live_q[`CSSUP_F_UV]   <= uv_s; // RULE16
      // Thresholds apart give hysteresis; between them the flag holds.
      if (above_warn_s) begin
        live_q[`CSSUP_F_TWARN] <= 1'b1; // RULE15
      end else if (below_clr_s) begin
        live_q[`CSSUP_F_TWARN] <= 1'b0; // RULE15
      end
      if (sw_below_s) begin
        live_q[`CSSUP_F_SWARN] <= 1'b1; // RULE17
      end else if (sw_above_s) begin
        live_q[`CSSUP_F_SWARN] <= 1'b0; // RULE17
      end
    end
  end

  // ----------------------------------------------------------------------
  // Latched copies and interrupt
  // ----------------------------------------------------------------------
  assign rise = live_q & ~live_prev_q; // RULE11

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_prev_q <= `CSSUP_FLAGS_RST;
    end else begin
      live_prev_q <= live_q;
    end
  end

  // A new rise in the cycle of a clearing read survives the clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      latched_q <= `CSSUP_FLAGS_RST;
    end else if (rd_status) begin
      latched_q <= rise; // RULE12
    end else if (wr_status) begin
      latched_q <= (latched_q & ~reg_wdata[7:4]) | rise;
    end else begin
      latched_q <= latched_q | rise; // RULE11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      global_status_irq <= 1'b0;
    end else begin
      global_status_irq <= |(latched_q & irq_en_q &
        {`CSSUP_WARN_ALWAYS, clock_q[`CSSUP_B_WARN_EN]}); // RULE1 RULE13
    end
  end

  // ----------------------------------------------------------------------
  // Clock source supervision
  // ----------------------------------------------------------------------
  logic             src_enabled;
  logic             src_level;
  logic             src_prev_q;
  logic             src_edge;
  logic [CNT_W-1:0] idle_cnt_q;

  assign src_enabled = clock_q[`CSSUP_B_EXT_EN] | clock_q[`CSSUP_B_XTAL_EN];
  // Both enables at once is illegal; the clock input then wins.
  assign src_level = clock_q[`CSSUP_B_EXT_EN] ? clkin_s : xtal_s;
  assign src_edge  = src_level ^ src_prev_q;
  assign crystal_osc_run = clock_q[`CSSUP_B_XTAL_EN]; // RULE9

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // The timeout is far shorter than the software settle time, so the
  // flag is stable well before software is allowed to trust it.
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !src_enabled || src_edge) begin
      idle_cnt_q <= '0;
      missing_q  <= 1'b0;
    end else if (idle_cnt_q == CNT_W'(MISS_CYC - 1)) begin
      missing_q  <= 1'b1; // RULE4
    end else begin
      idle_cnt_q <= idle_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b || missing_q || !src_enabled) begin
      framer_clk_src <= cssup_pkg::CSSUP_SRC_INTERNAL; // RULE4
    end else if (clock_q[`CSSUP_B_EXT_EN]) begin
      framer_clk_src <= cssup_pkg::CSSUP_SRC_EXT;
    end else begin
      framer_clk_src <= cssup_pkg::CSSUP_SRC_CRYSTAL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      framer_clk_ratio <= `CSSUP_RATIO_14M;
    end else begin
      case (clock_q[`CSSUP_B_DIV_HI:`CSSUP_B_DIV_LO])
        `CSSUP_DIV_14M: framer_clk_ratio <= `CSSUP_RATIO_14M; // RULE7
        `CSSUP_DIV_7M:  framer_clk_ratio <= `CSSUP_RATIO_7M; // RULE7
        default:        framer_clk_ratio <= `CSSUP_RATIO_3M; // RULE7
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Clock output
  // ----------------------------------------------------------------------
  // A phase accumulator gives the right mean rate; each half period
  // jitters by one system clock, which the output pin tolerates.
  logic [`CSSUP_ACC_W-1:0] acc_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || !clock_q[`CSSUP_B_CLOCK_OUT_PIN_EN]) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + CLOCK_OUT_PIN_INC; // RULE6
    end
  end

  assign clock_out_pin = acc_q[`CSSUP_ACC_W-1];

  // ----------------------------------------------------------------------
  // Line drive source
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      line_port_tx       <= '0;
      line_port_drive_en <= '0;
    end else if (clock_q[`CSSUP_B_OVERRIDE]) begin
      line_port_tx       <= tx_bit; // RULE2 RULE3
      line_port_drive_en <= line_drive_en_bit; // RULE2 RULE3
    end else begin
      line_port_tx       <= tx_pin_s; // RULE3
      line_port_drive_en <= en_pin_s; // RULE3
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_rise;
    rise != 4'h0;
  endsequence

  sequence s_read_clears;
    rd_status && (rise == 4'h0) ##1 (latched_q == 4'h0);
  endsequence

  a_latch_on_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_rise |=> ((latched_q & $past(rise)) == $past(rise))) // RULE11
    else $error("latched bit missed a rising live flag");

  a_latch_no_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rd_status && !wr_status && (rise == 4'h0)
    |=> latched_q == $past(latched_q)) // RULE11
    else $error("latched bit changed without a rise");

  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_status && (rise == 4'h0) |-> s_read_clears) // RULE12
    else $error("status read did not clear latched bits");

  a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_status |=> reg_rdata == {$past(latched_q), $past(live_q)}) // RULE12
    else $error("status read data wrong");

  a_warn_gated: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (latched_q[3:1] == 3'h0) && !clock_q[`CSSUP_B_WARN_EN]
    |=> !global_status_irq) // RULE1
    else $error("supply warning raised a disabled interrupt");

  a_irq_thermal: assert property (@(posedge sys_clk) disable iff (!rst_b)
    latched_q[`CSSUP_F_SHDN] && irq_en_q[`CSSUP_F_SHDN]
    |=> global_status_irq) // RULE13
    else $error("thermal shutdown did not raise interrupt");

  a_twarn_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    live_q[`CSSUP_F_TWARN] && !below_clr_s
    |=> live_q[`CSSUP_F_TWARN]) // RULE15
    else $error("thermal warning cleared above the clear threshold");

  a_swarn_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sw_below_s |=> live_q[`CSSUP_F_SWARN]) // RULE17
    else $error("supply warning flag did not set");

  a_override_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clock_q[`CSSUP_B_OVERRIDE] |=> line_port_tx == $past(tx_bit)
    && line_port_drive_en == $past(line_drive_en_bit)) // RULE2
    else $error("line outputs ignored override bits");

  a_pins_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clock_q[`CSSUP_B_OVERRIDE] |=> line_port_tx == $past(tx_pin_s)) // RULE3
    else $error("line outputs did not follow pins");

  a_miss_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    src_enabled && !src_edge && idle_cnt_q == CNT_W'(MISS_CYC - 1)
    |=> missing_q ##1 framer_clk_src == cssup_pkg::CSSUP_SRC_INTERNAL)
    // RULE4
    else $error("missing clock not flagged or not replaced");

  a_clock_out_pin_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clock_q[`CSSUP_B_CLOCK_OUT_PIN_EN] |=> !clock_out_pin) // RULE6
    else $error("clock output toggled while disabled");

  a_reset_clock: assert property (@(posedge sys_clk)
    !rst_b |=> clock_q == `CSSUP_CLOCK_RST) // RULE18
    else $error("clock register not cleared by reset");

endmodule

`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the clock select and supervisor register bank.
// Assumes the src files are compiled first and the header is on the path.
`include "cssup_defs.svh"
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       sys_clk = 1'b0;
  logic       rst_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd;
  logic       shdn_det, above_det, below_det, uv_det, bwarn_det, recov_det;
  logic       clock_in_pin = 1'b0;
  logic       crystal_osc_pin = 1'b0;
  logic       crystal_osc_run, clock_out_pin, global_status_irq;
  logic [1:0] framer_clk_src;
  logic [2:0] framer_clk_ratio;
  logic [1:0] tx_pin, line_drive_en_pin, tx_bit, line_drive_en_bit;
  logic [1:0] line_port_tx, line_port_drive_en;
  logic       ci_run = 1'b0;
  logic       xo_run = 1'b0;
  logic [1:0] ph = 2'h0;
  logic       clock_out_pin_prev = 1'b0;
  int         clock_out_pin_edges = 0;
  int         miscompares = 0;
  int         checks = 0;
  logic [3:0] live_m, lat_m, en_m;
  logic       warn_m;

  always #5 sys_clk = ~sys_clk;

  // A small value keeps the missing-clock wait short.
  cssup_top #(.CHANNELS(2), .MISS_CYC(8)) u_cssup_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .temp_shutdown_det(shdn_det),
    .temp_above_warn_det(above_det), .temp_below_clear_det(below_det),
    .supply_below_uv_det(uv_det), .supply_below_warn_det(bwarn_det),
    .supply_above_recov_det(recov_det), .clock_in_pin(clock_in_pin),
    .crystal_osc_pin(crystal_osc_pin), .crystal_osc_run(crystal_osc_run),
    .clock_out_pin(clock_out_pin), .framer_clk_src(framer_clk_src),
    .framer_clk_ratio(framer_clk_ratio), .tx_pin(tx_pin),
    .line_drive_en_pin(line_drive_en_pin), .tx_bit(tx_bit),
    .line_drive_en_bit(line_drive_en_bit), .line_port_tx(line_port_tx),
    .line_port_drive_en(line_port_drive_en),
    .global_status_irq(global_status_irq)
  );

  // ----------------------------------------------------------------------
  // External clock sources at 12.5 MHz and clock output edge counter
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    ph <= ph + 2'h1;
    clock_out_pin_prev <= clock_out_pin;
    if (clock_out_pin === 1'b1 && clock_out_pin_prev === 1'b0) begin
      clock_out_pin_edges <= clock_out_pin_edges + 1;
    end
    if (ci_run && ph == 2'h0) begin
      clock_in_pin <= ~clock_in_pin;
    end
    if (xo_run && ph == 2'h0) begin
      crystal_osc_pin <= ~crystal_osc_pin;
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks and expectation functions
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [2:0] ratio_of(input logic [1:0] c);
    if (c == `CSSUP_DIV_14M) begin
      return `CSSUP_RATIO_14M;
    end
    return (c == `CSSUP_DIV_7M) ? `CSSUP_RATIO_7M : `CSSUP_RATIO_3M;
  endfunction

  // Detector order: shutdown, above, below, uv, below warn, recovered.
  function automatic logic [3:0] next_live(input logic [3:0] o,
                                           input logic [5:0] d);
    logic tw;
    logic sw;
    tw = d[4] ? 1'b1 : (d[3] ? 1'b0 : o[2]);
    sw = d[1] ? 1'b1 : (d[0] ? 1'b0 : o[0]);
    return {d[5], tw, d[2], sw};
  endfunction

  function automatic logic irq_exp();
    return |(lat_m & en_m & {3'h7, warn_m});
  endfunction

  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0]  v;
    logic [31:0] r;
    logic [5:0]  d;
    logic [3:0]  old;
    int          n0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {shdn_det, above_det, below_det, uv_det, bwarn_det, recov_det} = '0;
    {tx_pin, line_drive_en_pin, tx_bit, line_drive_en_bit} = '0;
    {live_m, lat_m, en_m, warn_m} = {12'h00F, 1'b0};
    rst_b = 1'b0;
    void'($urandom(15472));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_cyc(1);
    `CHK("ratio", `CSSUP_RATIO_14M, framer_clk_ratio)
    `CHK("clock_out_pin", 1'b0, clock_out_pin)
    rd(`CSSUP_OFS_CLOCK, `CSSUP_CLOCK_RST);
    rd(`CSSUP_OFS_STATUS, 8'h00);
    rd(`CSSUP_OFS_IRQ_EN, 8'h0F);
    rd(8'h55, 8'h00);
    wr(`CSSUP_OFS_CLOCK, 8'h20);
    wr(8'h55, 8'hFF);
    rd(`CSSUP_OFS_CLOCK, 8'h00);
    // Random configuration with line drive from pins or register bits.
    repeat (24) begin
      v = 8'($urandom) & 8'hDC;
      @(posedge sys_clk);
      tx_pin <= 2'($urandom);
      line_drive_en_pin <= 2'($urandom);
      tx_bit <= 2'($urandom);
      line_drive_en_bit <= 2'($urandom);
      wr(`CSSUP_OFS_CLOCK, v);
      wait_cyc(4);
      `CHK("tx", v[6] ? tx_bit : tx_pin, line_port_tx)
      `CHK("en", v[6] ? line_drive_en_bit : line_drive_en_pin,
           line_port_drive_en)
      `CHK("ratio", ratio_of(v[3:2]), framer_clk_ratio)
      rd(`CSSUP_OFS_CLOCK, v);
    end
    wr(`CSSUP_OFS_CLOCK, 8'h10);
    n0 = clock_out_pin_edges;
    wait_cyc(1000);
    `CHK("clock_out_pin_rate", 1'b1,
         (clock_out_pin_edges - n0 >= 35 && clock_out_pin_edges - n0 <= 38))
    wr(`CSSUP_OFS_CLOCK, 8'h00);
    wait_cyc(4);
    n0 = clock_out_pin_edges;
    wait_cyc(200);
    `CHK("clock_out_pin_off", 0, clock_out_pin_edges - n0)
    // External input clock runs, stops and is flagged missing.
    wr(`CSSUP_OFS_CLOCK, 8'h02);
    ci_run = 1'b1;
    wait_cyc(20);
    `CHK("src", 2'(cssup_pkg::CSSUP_SRC_EXT), framer_clk_src)
    rd(`CSSUP_OFS_CLOCK, 8'h02);
    ci_run = 1'b0;
    wait_cyc(20);
    rd(`CSSUP_OFS_CLOCK, 8'h22);
    `CHK("src", 2'(cssup_pkg::CSSUP_SRC_INTERNAL), framer_clk_src)
    // Crystal oscillator starts, runs and fails.
    wr(`CSSUP_OFS_CLOCK, 8'h01);
    wait_cyc(2);
    `CHK("xo_run", 1'b1, crystal_osc_run)
    xo_run = 1'b1;
    wait_cyc(20);
    `CHK("src", 2'(cssup_pkg::CSSUP_SRC_CRYSTAL), framer_clk_src)
    xo_run = 1'b0;
    wait_cyc(20);
    rd(`CSSUP_OFS_CLOCK, 8'h21);
    `CHK("src", 2'(cssup_pkg::CSSUP_SRC_INTERNAL), framer_clk_src)
    wr(`CSSUP_OFS_CLOCK, 8'h00);
    // Random detector activity with masking and both clearing paths.
    repeat (80) begin
      r = $urandom;
      if (r[8]) begin
        wr(`CSSUP_OFS_CLOCK, {r[9], 7'h00});
        warn_m = r[9];
      end
      if (r[10]) begin
        wr(`CSSUP_OFS_IRQ_EN, {4'h0, r[14:11]});
        en_m = r[14:11];
      end
      d = {r[0], r[3:2] == 2'h0, r[3:2] == 2'h2, r[1],
           r[5:4] == 2'h0, r[5:4] == 2'h2};
      @(posedge sys_clk);
      {shdn_det, above_det, below_det, uv_det, bwarn_det, recov_det} <= d;
      wait_cyc(6);
      old = live_m;
      live_m = next_live(old, d);
      lat_m = lat_m | (live_m & ~old);
      `CHK("irq", irq_exp(), global_status_irq)
      if (r[15]) begin
        rd(`CSSUP_OFS_STATUS,
           {lat_m, live_m});
        lat_m = 4'h0;
        wait_cyc(1);
        `CHK("irq_rd", 1'b0, global_status_irq)
      end else if (r[16]) begin
        wr(`CSSUP_OFS_STATUS, {r[20:17], 4'h0});
        lat_m = lat_m & ~r[20:17];
        wait_cyc(1);
        `CHK("irq_w1c", irq_exp(), global_status_irq)
      end
    end
    rd(`CSSUP_OFS_STATUS, {lat_m, live_m});
    rd(`CSSUP_OFS_STATUS, {4'h0, live_m});
    report_and_stop();
  end
endmodule

`default_nettype wire
